// file: logic/fnpd_core.v
`timescale 1ns/1ps
`include "fnpd_defines.vh"

module fnpd_core (
    input wire CLK,             // System clock
    input wire RESET_N,         // Asynchronous reset
    input wire HSEL,            // Slave select
    input wire [31:0] HADDR,    // Address
    input wire [1:0] HTRANS,    // Transfer type
    input wire HWRITE,          // Write strobe
    input wire [2:0] HSIZE,     // Transfer size, word only
    input wire [31:0] HWDATA,   // Write data
    input wire HREADY,          // Bus ready
    input wire REF_IN,          // Reference clock from pin
    input wire VCO_IN,          // Oscillator feedback from pin
    output reg [31:0] HRDATA,   // Read data
    output reg HREADYOUT,       // Slave ready
    output reg HRESP,           // Slave response
    output reg PD_UP,           // Detector up to pump
    output reg PD_DN,           // Detector down to pump
    output reg SPLIT_DN,        // Down-split pulse
    output reg [1:0] SPLIT_AMP, // Down-split amplitude code
    output reg [4:0] LEAK_MAG,  // Leakage magnitude
    output reg LEAK_X2,         // Leakage base step doubled
    output reg LEAK_SRC,        // Leakage sources when high
    output reg REF_CMP,         // Reference-divided pulse
    output reg FB_CMP           // Feedback-divided pulse
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg [16:0] nint_reg;
    reg [20:0] frac_reg;
    reg [20:0] frac_modulus_reg;
    reg [15:0] refc_reg;
    reg [3:0] fbc_reg;
    reg [11:0] pdc_reg;
    reg wph_reg;
    reg [7:0] waddr_reg;
    reg [31:0] rmux;
    reg [31:0] rmask;
    reg ref_s1_reg, ref_s2_reg, ref_s3_reg;
    reg vco_s1_reg, vco_s2_reg, vco_s3_reg;
    reg [1:0] psc_reg;
    reg [12:0] rcnt_reg;
    reg fbh_reg;
    reg [17:0] ncnt_reg;
    reg [17:0] ratio_reg;
    reg [21:0] acc_reg [0:3];
    reg signed [5:0] tp_reg [0:3];
    reg rst_act_reg;
    reg [2:0] rcyc_reg;
    reg [4:0] scnt_reg;
    reg [31:0] pd_delay_full;
    wire [2:0] pd_delay_cyc = pd_delay_full[2:0];
    wire [1:0] pd_delay_sign_sel = pdc_reg[`FNPD_PDC_SIGN];
    wire [1:0] pd_delay_value = pdc_reg[`FNPD_PDC_DVAL];
    wire down_split_en = pdc_reg[`FNPD_PDC_DSPL];
    wire dither_bit = fbc_reg[`FNPD_FBC_DITH];
    wire [1:0] mash_order = fbc_reg[`FNPD_FBC_ORD];
    wire ref_rise = ref_s2_reg & ~ref_s3_reg;
    wire ref_edge = ref_s2_reg ^ ref_s3_reg;
    wire vco_tick = vco_s2_reg & ~vco_s3_reg;
    wire int_mode = nint_reg >= `FNPD_NINT_INTMIN;
    wire [21:0] mod2 = {frac_modulus_reg, 1'b0};
    wire [21:0] inc = {frac_reg, dither_bit};
    wire [22:0] sum_w [0:3];
    wire [3:0] carry_w;
    wire [21:0] res_w [0:3];
    wire signed [5:0] tv_w [0:4];
    wire signed [5:0] tpv_w [0:4];
    wire ref_tick;
    wire fbd_tick;
    wire [17:0] ratio_new;
    wire [12:0] r_div;
    wire ref_pulse;
    wire fb_pulse;
    wire [31:0] abl_full = `FNPD_CYC(`FNPD_ABL_PS);
    wire [2:0] abl_cyc = abl_full[2:0];
    wire [2:0] up_lim;
    wire [2:0] dn_lim;
    wire up_clr;
    wire dn_clr;
    wire wr_nint = wph_reg && waddr_reg == `FNPD_OFF_NINT;
    wire wr_frac = wph_reg && waddr_reg == `FNPD_OFF_FRAC;
    wire wr_mod = wph_reg && waddr_reg == `FNPD_OFF_MOD;
    wire wr_refc = wph_reg && waddr_reg == `FNPD_OFF_REFC;
    wire wr_fbc = wph_reg && waddr_reg == `FNPD_OFF_FBC;
    wire wr_pdc = wph_reg && waddr_reg == `FNPD_OFF_PDC;
    wire aph = HSEL && HTRANS[1] && HREADY;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // Read mux on the address phase address
    always @* begin
        rmux = 32'h00000000;
        rmask = 32'h00000000;
        case (HADDR[7:0])
            `FNPD_OFF_NINT: begin
                rmux = {15'h0000, nint_reg};
                rmask = `FNPD_MSK_NINT;
            end
            `FNPD_OFF_FRAC: begin
                rmux = {11'h000, frac_reg};
                rmask = `FNPD_MSK_FRAC;
            end
            `FNPD_OFF_MOD: begin
                rmux = {11'h000, frac_modulus_reg};
                rmask = `FNPD_MSK_FRAC;
            end
            `FNPD_OFF_REFC: begin
                rmux = {16'h0000, refc_reg};
                rmask = `FNPD_MSK_REFC;
            end
            `FNPD_OFF_FBC: begin
                rmux = {28'h0000000, fbc_reg};
                rmask = `FNPD_MSK_FBC;
            end
            `FNPD_OFF_PDC: begin
                rmux = {20'h00000, pdc_reg};
                rmask = `FNPD_MSK_PDC;
            end
            `FNPD_OFF_STAT: begin
                rmux = {28'h0000000, SPLIT_DN, PD_DN, PD_UP, int_mode};
            end
            default: begin
                rmux = 32'h00000000;
            end
        endcase
    end

    // Address phase capture, zero wait states, write forwarding
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wph_reg <= 1'b0;
            waddr_reg <= 8'h00;
            HRDATA <= 32'h00000000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            wph_reg <= aph && HWRITE;
            if (aph) begin
                waddr_reg <= HADDR[7:0];
            end
            if (aph && !HWRITE) begin
                if (wph_reg && waddr_reg == HADDR[7:0])
                    HRDATA <= HWDATA & rmask;
                else
                    HRDATA <= rmux;
            end
        end
    end

    // Configuration registers
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            nint_reg <= `FNPD_RST_NINT;
            frac_reg <= `FNPD_RST_FRAC;
            frac_modulus_reg <= `FNPD_RST_MOD;
            refc_reg <= `FNPD_RST_REFC;
            fbc_reg <= `FNPD_RST_FBC;
            pdc_reg <= `FNPD_RST_PDC;
        end else begin
            if (wr_nint)
                nint_reg <= HWDATA[`FNPD_NINT_F];
            if (wr_frac)
                frac_reg <= HWDATA[`FNPD_FRAC_F];
            if (wr_mod)
                frac_modulus_reg <= HWDATA[`FNPD_FRAC_F];
            if (wr_refc)
                refc_reg <= HWDATA[15:0];
            if (wr_fbc)
                fbc_reg <= HWDATA[3:0];
            if (wr_pdc)
                pdc_reg <= HWDATA[11:0];
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Two flops on each pin, third for edge detection
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ref_s1_reg <= 1'b0;
            ref_s2_reg <= 1'b0;
            ref_s3_reg <= 1'b0;
            vco_s1_reg <= 1'b0;
            vco_s2_reg <= 1'b0;
            vco_s3_reg <= 1'b0;
        end else begin
            ref_s1_reg <= REF_IN;
            ref_s2_reg <= ref_s1_reg;
            ref_s3_reg <= ref_s2_reg;
            vco_s1_reg <= VCO_IN;
            vco_s2_reg <= vco_s1_reg;
            vco_s3_reg <= vco_s2_reg;
        end
    end

    // ------------------------------------------------------------
    // Reference path
    // ------------------------------------------------------------
    // Doubler counts both edges and overrides the prescaler
    assign ref_tick = refc_reg[`FNPD_REFC_DBL] ? ref_edge :
        (refc_reg[`FNPD_REFC_PSC] == `FNPD_PSC_DIV2) ?
            (ref_rise && psc_reg[0]) :
        (refc_reg[`FNPD_REFC_PSC] == `FNPD_PSC_DIV4) ?
            (ref_rise && psc_reg == 2'h3) : ref_rise;
    assign r_div = (refc_reg[`FNPD_REFC_R] == 13'h0000) ? 13'h0001 :
        refc_reg[`FNPD_REFC_R];
    assign ref_pulse = ref_tick && (rcnt_reg >= r_div - 13'h0001);

    // Prescaler and 13-bit reference counter
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            psc_reg <= 2'h0;
            rcnt_reg <= 13'h0000;
        end else begin
            if (ref_rise)
                psc_reg <= psc_reg + 2'h1;
            if (ref_pulse)
                rcnt_reg <= 13'h0000;
            else if (ref_tick)
                rcnt_reg <= rcnt_reg + 13'h0001;
        end
    end

    // ------------------------------------------------------------
    // Fractional modulator
    // ------------------------------------------------------------
    // Accumulators on twice the modulus carry the dither half step
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_mash
            wire [21:0] stin = (gi == 0) ? inc : res_w[(gi == 0) ? 0 : gi - 1];
            wire en = (gi <= mash_order);
            assign sum_w[gi] = {1'b0, acc_reg[gi]} + {1'b0, stin};
            assign carry_w[gi] = en && (sum_w[gi] >= {1'b0, mod2});
            assign res_w[gi] = carry_w[gi] ?
                (sum_w[gi][21:0] - mod2) : sum_w[gi][21:0];
            assign tpv_w[gi] = tp_reg[gi];
            assign tv_w[gi] = en ? ($signed({5'h00, carry_w[gi]}) +
                tv_w[gi + 1] - tpv_w[gi + 1]) : 6'sh00;
            always @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    acc_reg[gi] <= 22'h000000;
                    tp_reg[gi] <= 6'sh00;
                end else if (fb_pulse && !int_mode && en) begin
                    acc_reg[gi] <= res_w[gi];
                    tp_reg[gi] <= tv_w[gi];
                end
            end
        end
    endgenerate
    assign tv_w[4] = 6'sh00;
    assign tpv_w[4] = 6'sh00;

    // ------------------------------------------------------------
    // Feedback divider
    // ------------------------------------------------------------
    // Optional halving of the oscillator ahead of the counter
    assign fbd_tick = vco_tick && (!fbc_reg[`FNPD_FBC_FBPS] || fbh_reg);
    assign ratio_new = int_mode ? {1'b0, nint_reg} :
        ({1'b0, nint_reg} + {{12{tv_w[0][5]}}, tv_w[0]});
    assign fb_pulse = fbd_tick && (ncnt_reg >= ratio_reg - 18'h00001);

    // Divide counter reloads its ratio once per output period
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            fbh_reg <= 1'b0;
            ncnt_reg <= 18'h00000;
            ratio_reg <= {1'b0, `FNPD_RST_NINT};
        end else begin
            if (vco_tick)
                fbh_reg <= ~fbh_reg;
            if (fb_pulse) begin
                ncnt_reg <= 18'h00000;
                ratio_reg <= ratio_new;
            end else if (fbd_tick) begin
                ncnt_reg <= ncnt_reg + 18'h00001;
            end
        end
    end

    // ------------------------------------------------------------
    // Phase detector
    // ------------------------------------------------------------
    // Delay code to cycles; down-split borrows the code
    always @* begin
        case (down_split_en ? 2'h0 : pd_delay_value)
            2'h0: pd_delay_full = `FNPD_CYC(`FNPD_DEL0_PS);
            2'h1: pd_delay_full = `FNPD_CYC(`FNPD_DEL1_PS);
            2'h2: pd_delay_full = `FNPD_CYC(`FNPD_DEL2_PS);
            default: pd_delay_full = `FNPD_CYC(`FNPD_DEL3_PS);
        endcase
    end

    // Separate reset-path delay per side
    assign up_lim = abl_cyc + ((pd_delay_sign_sel == `FNPD_SIGN_REF) ?
        pd_delay_cyc : 3'h0);
    assign dn_lim = abl_cyc + ((pd_delay_sign_sel == `FNPD_SIGN_FB) ?
        pd_delay_cyc : 3'h0);
    assign up_clr = rst_act_reg && (rcyc_reg >= up_lim - 3'h1);
    assign dn_clr = rst_act_reg && (rcyc_reg >= dn_lim - 3'h1);

    // Up and down flops, a new edge wins over a clear
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PD_UP <= 1'b0;
            PD_DN <= 1'b0;
            rst_act_reg <= 1'b0;
            rcyc_reg <= 3'h0;
            REF_CMP <= 1'b0;
            FB_CMP <= 1'b0;
        end else begin
            REF_CMP <= ref_pulse;
            FB_CMP <= fb_pulse;
            if (ref_pulse)
                PD_UP <= 1'b1;
            else if (up_clr)
                PD_UP <= 1'b0;
            if (fb_pulse)
                PD_DN <= 1'b1;
            else if (dn_clr)
                PD_DN <= 1'b0;
            if (rst_act_reg && (up_clr || !PD_UP) && (dn_clr || !PD_DN)) begin
                rst_act_reg <= 1'b0;
                rcyc_reg <= 3'h0;
            end else if (rst_act_reg) begin
                rcyc_reg <= rcyc_reg + 3'h1;
            end else if (PD_UP && PD_DN) begin
                rst_act_reg <= 1'b1;
                rcyc_reg <= 3'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Spur compensation
    // ------------------------------------------------------------
    // Down-split pulse of 16 oscillator cycles after each reset
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SPLIT_DN <= 1'b0;
            scnt_reg <= 5'h00;
            SPLIT_AMP <= 2'h0;
            LEAK_MAG <= 5'h00;
            LEAK_X2 <= 1'b0;
            LEAK_SRC <= 1'b0;
        end else begin
            SPLIT_AMP <= down_split_en ? pd_delay_value : 2'h0;
            LEAK_MAG <= pdc_reg[`FNPD_PDC_LEAK];
            LEAK_X2 <= pdc_reg[`FNPD_PDC_LX2];
            LEAK_SRC <= pdc_reg[`FNPD_PDC_LDIR];
            if (down_split_en && PD_DN && dn_clr && !fb_pulse) begin
                SPLIT_DN <= 1'b1;
                scnt_reg <= 5'h00;
            end else if (SPLIT_DN && vco_tick) begin
                if (scnt_reg == `FNPD_SPLIT_LEN - 5'h01)
                    SPLIT_DN <= 1'b0;
                scnt_reg <= scnt_reg + 5'h01;
            end
        end
    end

endmodule // fnpd_core

// file: logic/fnpd_defines.vh
// Overview of operation
// - 13-bit reference counter divides by 1..8191
// - Selectable divide-by-two or divide-by-four reference prescaler
// - Two-bit field selects MASH order one to four
// - 17-bit integer feedback field, integer range 24..131071
// - Integer value 512 or more forces integer mode
// - Fraction equals numerator/modulus plus dither/(2*modulus)
// - Feedback divider accepts oscillator input up to 6 GHz
// - Feedback prescale bit halves oscillator before divider
// - One programmable delay line in detector reset path
// - Delay sign selects none, feedback or reference delayed
// - Delay codes give 1.2, 1.9, 2.5, 3.0 ns
// - Five-bit leakage magnitude plus base step doubling bit
// - Leakage direction zero sinks, one sources
// - Down-split pulse lasts 16 oscillator cycles per period
// - With down-split, delay code selects pulse amplitude
// - Detector compares edges, anti-backlash width by delay gate
// - Separate up and down outputs for pump
`ifndef FNPD_DEFINES_VH
`define FNPD_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FNPD_OFF_NINT 8'h00
`define FNPD_OFF_FRAC 8'h04
`define FNPD_OFF_MOD 8'h08
`define FNPD_OFF_REFC 8'h0c
`define FNPD_OFF_FBC 8'h10
`define FNPD_OFF_PDC 8'h14
`define FNPD_OFF_STAT 8'h18

// ----------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------
`define FNPD_NINT_F 16:0
`define FNPD_FRAC_F 20:0
`define FNPD_REFC_R 12:0
`define FNPD_REFC_PSC 14:13
`define FNPD_REFC_DBL 15
`define FNPD_FBC_ORD 1:0
`define FNPD_FBC_DITH 2
`define FNPD_FBC_FBPS 3
`define FNPD_PDC_DVAL 1:0
`define FNPD_PDC_SIGN 3:2
`define FNPD_PDC_LEAK 8:4
`define FNPD_PDC_LX2 9
`define FNPD_PDC_LDIR 10
`define FNPD_PDC_DSPL 11
`define FNPD_STAT_INTM 0
`define FNPD_STAT_UP 1
`define FNPD_STAT_DN 2
`define FNPD_STAT_SPL 3

// ----------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------
`define FNPD_MSK_NINT 32'h0001ffff
`define FNPD_MSK_FRAC 32'h001fffff
`define FNPD_MSK_REFC 32'h0000ffff
`define FNPD_MSK_FBC 32'h0000000f
`define FNPD_MSK_PDC 32'h00000fff
`define FNPD_RST_NINT 17'h00018
`define FNPD_RST_FRAC 21'h000000
`define FNPD_RST_MOD 21'h000002
`define FNPD_RST_REFC 16'h0001
`define FNPD_RST_FBC 4'h0
`define FNPD_RST_PDC 12'h004

// ----------------------------------------------------------------
// Encodings and limits
// ----------------------------------------------------------------
`define FNPD_PSC_DIV2 2'h1
`define FNPD_PSC_DIV4 2'h2
`define FNPD_SIGN_FB 2'h1
`define FNPD_SIGN_REF 2'h2
`define FNPD_NINT_INTMIN 17'h00200
`define FNPD_SPLIT_LEN 5'h10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FNPD_CLK_MHZ 100
`define FNPD_DEL0_PS 1200
`define FNPD_DEL1_PS 1900
`define FNPD_DEL2_PS 2500
`define FNPD_DEL3_PS 3000
`define FNPD_ABL_PS 3000
`define FNPD_CYC(ps) ((((ps) * `FNPD_CLK_MHZ) + 999999) / 1000000)

`endif

// file: verification/fnpd_core_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Checker on detector and divider outputs
// ----------------------------------------------------------------
module fnpd_core_assertions (
    input wire logic CLK,      // System clock
    input wire logic RESET_N,  // Asynchronous reset
    input wire logic VCO_IN,   // Oscillator pin
    input wire logic PD_UP,    // Detector up
    input wire logic PD_DN,    // Detector down
    input wire logic SPLIT_DN, // Down-split pulse
    input wire logic REF_CMP,  // Reference-divided pulse
    input wire logic FB_CMP    // Feedback-divided pulse
);
    logic vco_d_reg;
    logic [5:0] vcnt_reg;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // Oscillator rises counted while the split pulse stands
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            vco_d_reg <= 1'b0;
            vcnt_reg <= 6'h00;
        end else begin
            vco_d_reg <= VCO_IN;
            if (!SPLIT_DN)
                vcnt_reg <= 6'h00;
            else if (VCO_IN && !vco_d_reg)
                vcnt_reg <= vcnt_reg + 6'h01;
        end
    end
    property p_up_set;
        $rose(PD_UP) |-> REF_CMP;
    endproperty
    a_up_set: assert property (p_up_set)
        else $error("up rose without reference pulse");
    property p_dn_set;
        $rose(PD_DN) |-> FB_CMP;
    endproperty
    a_dn_set: assert property (p_dn_set)
        else $error("down rose without feedback pulse");
    property p_ref_pulse;
        REF_CMP |=> !REF_CMP;
    endproperty
    a_ref_pulse: assert property (p_ref_pulse)
        else $error("reference pulse longer than one cycle");
    property p_fb_pulse;
        FB_CMP |=> !FB_CMP;
    endproperty
    a_fb_pulse: assert property (p_fb_pulse)
        else $error("feedback pulse longer than one cycle");
    property p_both_clear;
        PD_UP && PD_DN |-> ##[1:3] !(PD_UP && PD_DN);
    endproperty
    a_both_clear: assert property (p_both_clear)
        else $error("up and down not cleared");
    property p_up_hold;
        $rose(PD_UP) && !PD_DN |=> PD_UP;
    endproperty
    a_up_hold: assert property (p_up_hold)
        else $error("up dropped before down arrived");
    property p_split_start;
        $rose(SPLIT_DN) |-> $past(PD_DN) && !PD_DN;
    endproperty
    a_split_start: assert property (p_split_start)
        else $error("split pulse not after down clears");
    property p_split_len;
        $fell(SPLIT_DN) |-> vcnt_reg inside {[6'd15:6'd17]};
    endproperty
    a_split_len: assert property (p_split_len)
        else $error("split pulse length wrong");
    cover property ($rose(SPLIT_DN));
    cover property (PD_UP && PD_DN);
    cover property (FB_CMP ##1 !FB_CMP);
endmodule // fnpd_core_assertions

bind fnpd_core fnpd_core_assertions chk_u (.CLK(CLK), .RESET_N(RESET_N),
    .VCO_IN(VCO_IN), .PD_UP(PD_UP), .PD_DN(PD_DN), .SPLIT_DN(SPLIT_DN),
    .REF_CMP(REF_CMP), .FB_CMP(FB_CMP));

// file: verification/fnpd_src_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Reference source and oscillator feedback
// ----------------------------------------------------------------
module fnpd_src_model (
    input wire logic run,  // Sources run while high
    output logic ref_clk,  // Reference to pin
    output logic vco_clk   // Oscillator feedback to pin
);
    // 12.5 MHz reference, still and low while stopped
    initial begin
        ref_clk = 1'b0;
        forever begin
            if (!run) begin
                ref_clk = 1'b0;
                @(posedge run);
                #3;
            end
            #40 ref_clk = ~ref_clk;
        end
    end
    // 16.7 MHz oscillator, far below the divider limit
    initial begin
        vco_clk = 1'b0;
        forever begin
            if (!run) begin
                vco_clk = 1'b0;
                @(posedge run);
                #3;
            end
            #30 vco_clk = ~vco_clk;
        end
    end
endmodule // fnpd_src_model

// file: verification/fnpd_tb.sv
`timescale 1ns/1ps
`include "fnpd_defines.vh"
module tb;
    logic CLK, RESET_N, HSEL, HWRITE, HREADYOUT, HRESP, REF_IN, VCO_IN, run;
    logic PD_UP, PD_DN, SPLIT_DN, LEAK_X2, LEAK_SRC, REF_CMP, FB_CMP;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0] HTRANS, SPLIT_AMP;
    logic [2:0] HSIZE;
    logic [4:0] LEAK_MAG;
    logic [7:0] offs [6];
    logic [31:0] rsts [6];
    logic [31:0] msks [6];
    logic [15:0] refs [5];
    int rgap [5];
    int err_count, total_checks, g, i, ua, da;
    // ------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------
    fnpd_core dut_u (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .REF_IN(REF_IN),
        .VCO_IN(VCO_IN), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .PD_UP(PD_UP), .PD_DN(PD_DN), .SPLIT_DN(SPLIT_DN),
        .SPLIT_AMP(SPLIT_AMP), .LEAK_MAG(LEAK_MAG), .LEAK_X2(LEAK_X2),
        .LEAK_SRC(LEAK_SRC), .REF_CMP(REF_CMP), .FB_CMP(FB_CMP));
    fnpd_src_model src_u (.run(run), .ref_clk(REF_IN), .vco_clk(VCO_IN));
    // Clock and hang guard
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    initial begin
        #600000;
        err_count++;
        wrap_up;
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // One single word transfer, read data left in rd
    task automatic bus(input logic [7:0] a, input logic w,
            input logic [31:0] wd);
        int n;
        n = 0;
        HSEL <= 1'b1;
        HADDR <= {24'h0, a};
        HTRANS <= 2'h2;
        HWRITE <= w;
        do begin
            @(posedge CLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 50);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        do begin
            @(posedge CLK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 100);
        rd = HRDATA;
    endtask
    // Sum of cnt periods of a divided pulse, two settling pulses first
    task automatic gaps(input logic fb, input int cnt);
        int n;
        g = 0;
        for (n = 0; n < cnt + 2; n++) begin
            do begin
                @(posedge CLK);
                if (n > 1)
                    g++;
            end while ((fb ? FB_CMP : REF_CMP) !== 1'b1 && g < 30000);
        end
    endtask
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        RESET_N = 1'b0;
        HSEL = 1'b0;
        HADDR = 32'h0;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HSIZE = 3'h2;
        HWDATA = 32'h0;
        run = 1'b0;
        err_count = 0;
        total_checks = 0;
        offs = '{`FNPD_OFF_NINT, `FNPD_OFF_FRAC, `FNPD_OFF_MOD,
            `FNPD_OFF_REFC, `FNPD_OFF_FBC, `FNPD_OFF_PDC};
        rsts = '{32'h18, 32'h0, 32'h2, 32'h1, 32'h0, 32'h4};
        msks = '{`FNPD_MSK_NINT, `FNPD_MSK_FRAC, 32'h001fffff,
            `FNPD_MSK_REFC, `FNPD_MSK_FBC, `FNPD_MSK_PDC};
        refs = '{16'h0003, 16'h2002, 16'h4001, 16'h8002, 16'ha002};
        rgap = '{24, 32, 32, 8, 8};
        repeat (12) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        // Reset values, then every field written to ones
        for (i = 0; i < 6; i++) begin
            bus(offs[i], 1'b0, 32'h0);
            chk(rd, rsts[i]);
            bus(offs[i], 1'b1, 32'hffffffff);
            bus(offs[i], 1'b0, 32'h0);
            chk(rd, msks[i]);
        end
        bus(8'h1c, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, HRESP}, 32'h0);
        // Integer mode flag at the 512 boundary
        bus(`FNPD_OFF_MOD, 1'b1, 32'h2);
        bus(`FNPD_OFF_FRAC, 1'b1, 32'h1);
        bus(`FNPD_OFF_FBC, 1'b1, 32'h0);
        bus(`FNPD_OFF_NINT, 1'b1, 32'h200);
        bus(`FNPD_OFF_STAT, 1'b0, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
        bus(`FNPD_OFF_NINT, 1'b1, 32'h1fe);
        bus(`FNPD_OFF_STAT, 1'b0, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
        // Reference chain ratios
        run <= 1'b1;
        for (i = 0; i < 5; i++) begin
            bus(`FNPD_OFF_REFC, 1'b1, {16'h0, refs[i]});
            gaps(1'b0, 1);
            chk(g, rgap[i]);
        end
        // Feedback ratios: fraction, dither, integer, halved input
        bus(`FNPD_OFF_NINT, 1'b1, 32'h1e);
        gaps(1'b1, 2);
        chk(g, 366);
        bus(`FNPD_OFF_FRAC, 1'b1, 32'h0);
        bus(`FNPD_OFF_FBC, 1'b1, 32'h4);
        gaps(1'b1, 4);
        chk(g, 726);
        bus(`FNPD_OFF_FRAC, 1'b1, 32'h1);
        bus(`FNPD_OFF_FBC, 1'b1, 32'h0);
        bus(`FNPD_OFF_NINT, 1'b1, 32'h200);
        gaps(1'b1, 1);
        chk(g, 3072);
        bus(`FNPD_OFF_FRAC, 1'b1, 32'h0);
        bus(`FNPD_OFF_NINT, 1'b1, 32'h18);
        bus(`FNPD_OFF_FBC, 1'b1, 32'h8);
        gaps(1'b1, 1);
        chk(g, 288);
        bus(`FNPD_OFF_FBC, 1'b1, 32'h0);
        // Reset delay per sign, code equal to the sign
        bus(`FNPD_OFF_REFC, 1'b1, 32'ha);
        for (i = 0; i < 4; i++) begin
            bus(`FNPD_OFF_PDC, 1'b1, i * 5);
            g = 0;
            do begin
                @(posedge CLK);
                #1;
                g++;
            end while (!(PD_UP === 1'b1 && PD_DN === 1'b1) && g < 3000);
            ua = 0;
            da = 0;
            for (g = 1; g < 5; g++) begin
                @(posedge CLK);
                #1;
                if (PD_UP !== 1'b1 && ua == 0)
                    ua = g;
                if (PD_DN !== 1'b1 && da == 0)
                    da = g;
            end
            chk(ua, (i == 2) ? 3 : 2);
            chk(da, (i == 1) ? 3 : 2);
        end
        // Leakage fields, sourcing then sinking
        bus(`FNPD_OFF_PDC, 1'b1, 32'h754);
        repeat (2) @(posedge CLK);
        chk({25'h0, LEAK_SRC, LEAK_X2, LEAK_MAG}, 32'h75);
        bus(`FNPD_OFF_PDC, 1'b1, 32'h004);
        repeat (2) @(posedge CLK);
        chk({25'h0, LEAK_SRC, LEAK_X2, LEAK_MAG}, 32'h0);
        // Down-split pulse and amplitude code
        bus(`FNPD_OFF_PDC, 1'b1, 32'h807);
        repeat (2) @(posedge CLK);
        chk({30'h0, SPLIT_AMP}, 32'h3);
        g = 0;
        do begin
            @(posedge CLK);
            g++;
        end while (SPLIT_DN !== 1'b1 && g < 3000);
        chk({31'h0, SPLIT_DN}, 32'h1);
        repeat (150) @(posedge CLK);
        bus(`FNPD_OFF_PDC, 1'b1, 32'h004);
        repeat (2) @(posedge CLK);
        chk({30'h0, SPLIT_AMP}, 32'h0);
        run <= 1'b0;
        wrap_up;
    end
endmodule // tb
